// >>> hdl/pcdfs_top.sv
// Purpose: Port C / port D low function select with APB register access and pin routing.
// Assumes: Pins and mode straps synchronous to pclk; APB4 master with byte strobes.
// Notes:   One wait-free access phase; pin drive is registered, so it lags inputs by one cycle.
//
// Design decision made here: the APB register port.
module pcdfs_top
	import pcdfs_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Chip operating mode
	input  wire logic        single_chip_mode,
	input  wire logic        rom_disabled,
	// External bus side
	input  wire logic [15:0] ext_addr,
	input  wire logic [15:0] ext_data_out,
	input  wire logic        ext_data_oe,
	output logic      [15:0] ext_data_in,
	// GPIO side
	input  wire logic [15:0] gpio_c_out,
	input  wire logic [15:0] gpio_c_dir,
	output logic      [15:0] gpio_c_in,
	input  wire logic [15:0] gpio_d_out,
	output logic      [15:0] gpio_d_in,
	// Port C pins
	input  wire logic [15:0] pc_pin_in,
	output logic      [15:0] pc_pin_out,
	output logic      [15:0] pc_pin_oe,
	// Port D low pins
	input  wire logic [15:0] pd_pin_in,
	output logic      [15:0] pd_pin_out,
	output logic      [15:0] pd_pin_oe
);

	logic [15:0] port_c_function_select_ff;
	logic [15:0] port_d_low_direction_ff;
	logic [15:0] port_d_low_function_select_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] nxt_prdata;
	logic        nxt_pslverr;
	logic        setup_ph;
	logic        wr_en;
	logic        hit_pc;
	logic        hit_pddir;
	logic        hit_pdfs;
	logic        hit_stat;
	logic [15:0] c_out;
	logic [15:0] c_oe;
	logic [15:0] c_sel;
	logic [15:0] d_out;
	logic [15:0] d_oe;
	logic [15:0] d_sel;
	logic [15:0] pc_pin_out_ff;
	logic [15:0] pc_pin_oe_ff;
	logic [15:0] pd_pin_out_ff;
	logic [15:0] pd_pin_oe_ff;
	logic [15:0] ext_data_in_ff;
	logic [15:0] gpio_c_in_ff;
	logic [15:0] gpio_d_in_ff;
	logic [31:0] stat_word;

	// Address decode
	assign hit_pc    = (paddr == PCDFS_PCFS_ADDR);
	assign hit_pddir = (paddr == PCDFS_PDDIR_ADDR);
	assign hit_pdfs  = (paddr == PCDFS_PDFS_ADDR);
	assign hit_stat  = (paddr == PCDFS_STAT_ADDR);
	assign setup_ph  = psel && !penable;
	// The write lands only at the completing edge of the access phase
	assign wr_en     = psel && penable && pready_ff && pwrite;
	assign stat_word = {c_sel, d_sel};

	always_comb begin
		nxt_prdata  = PCDFS_RD_ZERO;
		nxt_pslverr = 1'b0;
		if (hit_pc) begin
			nxt_prdata[PCDFS_W-1:0] = port_c_function_select_ff;
		end else if (hit_pddir) begin
			nxt_prdata[PCDFS_W-1:0] = port_d_low_direction_ff;
		end else if (hit_pdfs) begin
			nxt_prdata[PCDFS_W-1:0] = port_d_low_function_select_ff;
		end else if (hit_stat) begin
			nxt_prdata = stat_word;
		end else begin
			nxt_pslverr = 1'b1;
		end
		// Status is read-only; a write to it is flagged rather than silently dropped
		if (hit_stat && pwrite) begin
			nxt_pslverr = 1'b1;
		end
		if (pwrite) begin
			nxt_prdata = PCDFS_RD_ZERO;
		end
	end

	// Answer is prepared in setup so read data leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= PCDFS_RD_ZERO;
		end else begin
			pready_ff  <= setup_ph;
			pslverr_ff <= setup_ph && nxt_pslverr;
			if (setup_ph) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_c_function_select_ff <= PCDFS_RST_VAL;
		end else if (wr_en && hit_pc) begin
			port_c_function_select_ff <= pcdfs_merge(port_c_function_select_ff, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_d_low_direction_ff <= PCDFS_RST_VAL;
		end else if (wr_en && hit_pddir) begin
			port_d_low_direction_ff <= pcdfs_merge(port_d_low_direction_ff, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_d_low_function_select_ff <= PCDFS_RST_VAL;
		end else if (wr_en && hit_pdfs) begin
			port_d_low_function_select_ff <= pcdfs_merge(port_d_low_function_select_ff, pwdata, pstrb);
		end
	end

	// Port C: alternate function is the address line, always driven
	pcdfs_pin_route u_route_c (
		.fn_sel      (port_c_function_select_ff),
		.single_chip (single_chip_mode),
		.rom_off     (rom_disabled),
		.gpio_out    (gpio_c_out),
		.gpio_dir    (gpio_c_dir),
		.alt_out     (ext_addr),
		.alt_oe      (PCDFS_ALL_ONES),
		.pin_out     (c_out),
		.pin_oe      (c_oe),
		.alt_sel     (c_sel)
	);

	// Port D low: alternate function is the bidirectional data line
	pcdfs_pin_route u_route_d (
		.fn_sel      (port_d_low_function_select_ff),
		.single_chip (single_chip_mode),
		.rom_off     (rom_disabled),
		.gpio_out    (gpio_d_out),
		.gpio_dir    (port_d_low_direction_ff),
		.alt_out     (ext_data_out),
		.alt_oe      ({PCDFS_W{ext_data_oe}}),
		.pin_out     (d_out),
		.pin_oe      (d_oe),
		.alt_sel     (d_sel)
	);

	// Pin drive registered; reset leaves every pin an undriven input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_pin_out_ff <= PCDFS_RST_VAL;
			pc_pin_oe_ff  <= PCDFS_RST_VAL;
			pd_pin_out_ff <= PCDFS_RST_VAL;
			pd_pin_oe_ff  <= PCDFS_RST_VAL;
		end else begin
			pc_pin_out_ff <= c_out;
			pc_pin_oe_ff  <= c_oe;
			pd_pin_out_ff <= d_out;
			pd_pin_oe_ff  <= d_oe;
		end
	end

	// Inputs returned only to whichever function owns the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_data_in_ff <= PCDFS_RST_VAL;
			gpio_c_in_ff   <= PCDFS_RST_VAL;
			gpio_d_in_ff   <= PCDFS_RST_VAL;
		end else begin
			ext_data_in_ff <= pd_pin_in & d_sel;
			gpio_c_in_ff   <= pc_pin_in & ~c_sel;
			gpio_d_in_ff   <= pd_pin_in & ~d_sel;
		end
	end

	assign pc_pin_out  = pc_pin_out_ff;
	assign pc_pin_oe   = pc_pin_oe_ff;
	assign pd_pin_out  = pd_pin_out_ff;
	assign pd_pin_oe   = pd_pin_oe_ff;
	assign ext_data_in = ext_data_in_ff;
	assign gpio_c_in   = gpio_c_in_ff;
	assign gpio_d_in   = gpio_d_in_ff;

	a_pc_addr_route: assert property (@(posedge pclk) disable iff (!presetn)
		(!single_chip_mode && !rom_disabled) |=> (pc_pin_out ==
		(($past(port_c_function_select_ff) & $past(ext_addr)) | (~$past(port_c_function_select_ff) & $past(gpio_c_out)))))
		else $error("port C pin output does not follow its function bits");

	a_pc_single_gpio: assert property (@(posedge pclk) disable iff (!presetn)
		single_chip_mode |=> (pc_pin_oe == $past(gpio_c_dir)) && (pc_pin_out == $past(gpio_c_out)))
		else $error("port C left GPIO in single-chip mode");

	a_pc_rom_off_addr: assert property (@(posedge pclk) disable iff (!presetn)
		(rom_disabled && !single_chip_mode) |=> (pc_pin_out == $past(ext_addr)) && (pc_pin_oe == PCDFS_ALL_ONES))
		else $error("port C not driving address with ROM disabled");

	a_pc_reg_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_pc && pstrb[1:0] == 2'h3) |=> port_c_function_select_ff == $past(pwdata[15:0]))
		else $error("port C function select write lost");

	a_pddir_byte_lane: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_pddir && pstrb[1:0] == 2'h1) |=>
		(port_d_low_direction_ff[15:8] == $past(port_d_low_direction_ff[15:8])) &&
		(port_d_low_direction_ff[7:0] == $past(pwdata[7:0])))
		else $error("port D direction byte write touched wrong lane");

	a_pdfs_read_back: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && hit_pdfs && !pwrite) ##1 (psel && penable) |->
		pready && (prdata == {16'h0000, $past(port_d_low_function_select_ff)}))
		else $error("port D function select read data wrong");

	a_pd_data_route: assert property (@(posedge pclk) disable iff (!presetn)
		(!single_chip_mode && !rom_disabled && ext_data_oe) |=>
		((pd_pin_oe & $past(port_d_low_function_select_ff)) == $past(port_d_low_function_select_ff)))
		else $error("port D data line not driven where selected");

	a_pd_gpio_dir: assert property (@(posedge pclk) disable iff (!presetn)
		single_chip_mode |=> (pd_pin_oe == $past(port_d_low_direction_ff)) && (pd_pin_out == $past(gpio_d_out)))
		else $error("port D GPIO drive does not follow direction bits");

	a_bus_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !(hit_pc || hit_pddir || hit_pdfs || hit_stat)) |=> pready && pslverr)
		else $error("unmapped access not answered with error");

	c_pc_write:    cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_pc);
	c_pd_byte_wr:  cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_pddir && pstrb == 4'h2);
	c_rom_off_pd:  cover property (@(posedge pclk) disable iff (!presetn) rom_disabled && !single_chip_mode && ext_data_oe);
	c_stat_read:   cover property (@(posedge pclk) disable iff (!presetn) pready && hit_stat && !pwrite);

endmodule : pcdfs_top

// >>> pkg/pcdfs_pkg.sv
// Purpose: Constants, register map and routing function for the port C / port D function select block.
// Assumes: APB4 slave with 32-bit data, each 16-bit register in the low half of one aligned word; status fills a whole word.
// Notes:   Printed register offsets are indices; the byte address is four times the index.
package pcdfs_pkg;

	localparam int          PCDFS_W         = 16;

	// Register indices as printed; the bus address is four times these
	localparam logic [31:0] PCDFS_PCFS_IDX  = 32'hffff839c;
	localparam logic [31:0] PCDFS_PDDIR_IDX = 32'hffff83a6;
	localparam logic [31:0] PCDFS_PDFS_IDX  = 32'hffff83ac;
	localparam logic [31:0] PCDFS_STAT_IDX  = 32'hffff83a0;

	localparam logic [31:0] PCDFS_PCFS_ADDR  = {PCDFS_PCFS_IDX[29:0], 2'h0};
	localparam logic [31:0] PCDFS_PDDIR_ADDR = {PCDFS_PDDIR_IDX[29:0], 2'h0};
	localparam logic [31:0] PCDFS_PDFS_ADDR  = {PCDFS_PDFS_IDX[29:0], 2'h0};
	localparam logic [31:0] PCDFS_STAT_ADDR  = {PCDFS_STAT_IDX[29:0], 2'h0};

	localparam logic [15:0] PCDFS_RST_VAL   = 16'h0000;
	localparam logic [15:0] PCDFS_ALL_ONES  = 16'hffff;
	localparam logic [31:0] PCDFS_RD_ZERO   = 32'h0000_0000;

	// Byte lanes of the 16-bit registers
	localparam int          PCDFS_LO_LSB    = 0;
	localparam int          PCDFS_HI_LSB    = 8;
	localparam int          PCDFS_STAT_DLSB = 16;

	// Pins whose alternate function is active, per chip mode
	function automatic logic [15:0] pcdfs_alt_mask(
		input logic [15:0] fn_sel,
		input logic        single_chip,
		input logic        rom_off
	);
		logic [15:0] m;
		m = fn_sel | (rom_off ? PCDFS_ALL_ONES : PCDFS_RST_VAL);
		pcdfs_alt_mask = single_chip ? PCDFS_RST_VAL : m;
	endfunction : pcdfs_alt_mask

	// 16-bit register update under APB byte strobes
	function automatic logic [15:0] pcdfs_merge(
		input logic [15:0] cur,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [15:0] v;
		v = cur;
		if (strb[0]) begin
			v[PCDFS_LO_LSB +: 8] = wdata[PCDFS_LO_LSB +: 8];
		end
		if (strb[1]) begin
			v[PCDFS_HI_LSB +: 8] = wdata[PCDFS_HI_LSB +: 8];
		end
		pcdfs_merge = v;
	endfunction : pcdfs_merge

endpackage : pcdfs_pkg

// >>> hdl/pcdfs_pin_route.sv
// Purpose: Per-pin choice between GPIO and one external bus line for a 16-pin port.
// Assumes: Alternate function drives whenever alt_oe is high for that pin.
// Notes:   Purely combinational; the top registers the pin drive.
module pcdfs_pin_route
	import pcdfs_pkg::*;
(
	// Configuration
	input  wire logic [15:0] fn_sel,
	input  wire logic        single_chip,
	input  wire logic        rom_off,
	// GPIO side
	input  wire logic [15:0] gpio_out,
	input  wire logic [15:0] gpio_dir,
	// Alternate side
	input  wire logic [15:0] alt_out,
	input  wire logic [15:0] alt_oe,
	// Pin side
	output logic      [15:0] pin_out,
	output logic      [15:0] pin_oe,
	output logic      [15:0] alt_sel
);

	always_comb begin
		alt_sel = pcdfs_alt_mask(fn_sel, single_chip, rom_off);
		pin_out = (alt_sel & alt_out) | (~alt_sel & gpio_out);
		pin_oe  = (alt_sel & alt_oe) | (~alt_sel & gpio_dir);
	end

endmodule : pcdfs_pin_route

// >>> tb/pcdfs_ext_bus_model.sv
// Purpose: Far side of the port C / port D pads: external memory and peripherals on the bus.
// Assumes: Each pad resolves to the device drive when its enable is high, else to the far drive.
// Notes:   Far drive comes from the bench so that released pads never echo the last device value.
module pcdfs_ext_bus_model (
	// Device pad drive
	input  wire logic [15:0] pc_pin_out,
	input  wire logic [15:0] pc_pin_oe,
	input  wire logic [15:0] pd_pin_out,
	input  wire logic [15:0] pd_pin_oe,
	// Far-side drive
	input  wire logic [15:0] far_c,
	input  wire logic [15:0] far_d,
	// Resolved pad levels
	output logic      [15:0] pc_pin_in,
	output logic      [15:0] pd_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pc_pin_in = (pc_pin_oe & pc_pin_out) | (~pc_pin_oe & far_c);
	assign pd_pin_in = (pd_pin_oe & pd_pin_out) | (~pd_pin_oe & far_d);
endmodule : pcdfs_ext_bus_model

// >>> tb/pcdfs_top_tb_top.sv
// Purpose: Self-checking bench for the port C / port D function select block.
// Assumes: Zero-wait APB slave; pads settle within a few cycles of any input change.
// Notes:   Expected routing is worked out here from the chip mode and register values.
module pcdfs_top_tb_top
	import pcdfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, sc, rom, doe, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr;
	logic [15:0] ea, edo, edi, gco, gcd, gci, gdo, gdi, pci, pco, pcoe, pdi, pdo, pdoe, far_c, far_d;
	int          fail_count, check_count;

	pcdfs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.single_chip_mode(sc), .rom_disabled(rom), .ext_addr(ea), .ext_data_out(edo), .ext_data_oe(doe),
		.ext_data_in(edi), .gpio_c_out(gco), .gpio_c_dir(gcd), .gpio_c_in(gci), .gpio_d_out(gdo),
		.gpio_d_in(gdi), .pc_pin_in(pci), .pc_pin_out(pco), .pc_pin_oe(pcoe), .pd_pin_in(pdi),
		.pd_pin_out(pdo), .pd_pin_oe(pdoe));
	pcdfs_ext_bus_model i_far (.pc_pin_out(pco), .pc_pin_oe(pcoe), .pd_pin_out(pdo), .pd_pin_oe(pdoe),
		.far_c(far_c), .far_d(far_d), .pc_pin_in(pci), .pd_pin_in(pdi));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready", 32'h1, 32'h0);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(nm, exp, rd);
		// Every mapped read must complete without an error response
		chk({nm, " err"}, 32'h0, {31'h0, err});
	endtask : rdchk

	task automatic t_reset();
		rdchk("pc_fs reset", PCDFS_PCFS_ADDR, 32'h0);
		rdchk("pd_dir reset", PCDFS_PDDIR_ADDR, 32'h0);
		rdchk("pd_fs reset", PCDFS_PDFS_ADDR, 32'h0);
	endtask : t_reset

	task automatic t_rw();
		apb(1'b1, PCDFS_PCFS_ADDR, 32'h0000_ffff, 4'h3);
		rdchk("pc_fs rw", PCDFS_PCFS_ADDR, 32'h0000_ffff);
		apb(1'b1, PCDFS_PDFS_ADDR, 32'h0000_a55a, 4'hf);
		rdchk("pd_fs rw", PCDFS_PDFS_ADDR, 32'h0000_a55a);
		apb(1'b1, PCDFS_PDDIR_ADDR, 32'h0000_ffff, 4'hf);
		apb(1'b1, PCDFS_PDDIR_ADDR, 32'h0000_1234, 4'h1);
		rdchk("pd_dir byte lo", PCDFS_PDDIR_ADDR, 32'h0000_ff34);
		apb(1'b1, PCDFS_PDDIR_ADDR, 32'h0000_5600, 4'h2);
		rdchk("pd_dir byte hi", PCDFS_PDDIR_ADDR, 32'h0000_5634);
	endtask : t_rw

	task automatic t_err();
		apb(1'b1, 32'h0000_0010, 32'h0000_ffff, 4'h3);
		chk("unmapped wr err", 32'h1, {31'h0, err});
		apb(1'b0, 32'h0000_0010, 32'h0, 4'h0);
		chk("unmapped rd err", 32'h1, {31'h0, err});
		chk("unmapped rd data", 32'h0, rd);
		// Status is read-only: a write must be flagged with an error response
		apb(1'b1, PCDFS_STAT_ADDR, 32'h0000_ffff, 4'h3);
		chk("status wr err", 32'h1, {31'h0, err});
	endtask : t_err

	// Every chip mode with a mix of function, direction and far-side values
	task automatic t_route();
		logic [15:0] fc, fd, dd, ac, ad, xpc, xpd;
		fc = 16'h0ff0;
		fd = 16'h3c3c;
		dd = 16'h5555;
		apb(1'b1, PCDFS_PCFS_ADDR, {16'h0, fc}, 4'h3);
		apb(1'b1, PCDFS_PDFS_ADDR, {16'h0, fd}, 4'h3);
		apb(1'b1, PCDFS_PDDIR_ADDR, {16'h0, dd}, 4'h3);
		for (int m = 0; m < 4; m++) begin
			sc <= m[1];
			rom <= m[0];
			doe <= (m != 1);
			repeat (4) @(posedge pclk);
			ac = sc ? 16'h0 : (fc | {16{rom}});
			ad = sc ? 16'h0 : (fd | {16{rom}});
			xpc = (ac & ea) | (~ac & gco);
			xpd = (ad & edo) | (~ad & gdo);
			chk("pc_pin_out", {16'h0, xpc}, {16'h0, pco});
			chk("pc_pin_oe", {16'h0, ac | gcd}, {16'h0, pcoe});
			chk("pd_pin_out", {16'h0, xpd}, {16'h0, pdo});
			chk("pd_pin_oe", {16'h0, (ad & {16{doe}}) | (~ad & dd)}, {16'h0, pdoe});
			xpd = ({16{doe}} & ad) | (~ad & dd);
			xpd = (xpd & xpd & ((ad & edo) | (~ad & gdo))) | (~xpd & far_d);
			chk("ext_data_in", {16'h0, xpd & ad}, {16'h0, edi});
			chk("gpio_d_in", {16'h0, xpd & ~ad}, {16'h0, gdi});
			chk("gpio_c_in", {16'h0, ~ac & ((gcd & gco) | (~gcd & far_c))}, {16'h0, gci});
			rdchk("status", PCDFS_STAT_ADDR, {ac, ad});
		end
	endtask : t_route

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	initial begin
		#100us;
		fail_count++;
		summarize();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, sc, rom, doe} = 6'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		ea = 16'ha5c3;
		edo = 16'h9e17;
		gco = 16'h1248;
		gcd = 16'hc0c3;
		gdo = 16'h7b21;
		far_c = 16'h6d4e;
		far_d = 16'hb2d9;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rw();
		t_err();
		t_route();
		summarize();
	end
endmodule : pcdfs_top_tb_top
